/* hdl/itb_pkg.sv */
// Shared constants and carrier types for the transponder base link
// Assumes a single 200 MHz clock domain and an asynchronous active-high reset
`default_nettype none
package itb_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int SYS_HZ = 4_000_000;
    localparam int CARRIER_HZ = 125_000;
    localparam int DIV_BITS = 14;
    // Half periods of the 4 MHz reference and of the carrier
    localparam int SYS_HALF_CYC = CLK_HZ / SYS_HZ / 2;
    localparam int CAR_HALF_TICKS = SYS_HZ / CARRIER_HZ / 2;
    localparam int SETTLE_MS = 30;
    localparam int SETTLE_CYC = (CLK_HZ / 1000) * SETTLE_MS;
    localparam int ACK_PAIRS = 3;
    localparam int OPCODE_BITS = 5;
    localparam int CMD_START_TE = 2;
    localparam int CMD_ONE_TE = 6;
    localparam int CMD_ZERO_TE = 4;
    localparam int RX_SHORT_BITS = 18;
    localparam int RX_LONG_BITS = 34;
    localparam int PREAMBLE_BITS = 2;
    localparam int TE_W = 20;
    localparam logic [TE_W-1:0] TE_RESET = 20'h00000;
    localparam logic [1:0] LEARN_IDLE = 2'h0;
    localparam logic [1:0] LEARN_BUSY = 2'h1;
    localparam logic [1:0] LEARN_DONE = 2'h2;

    typedef struct packed {
        logic [4:0] opcode;
        logic [31:0] data;
        logic [5:0] data_bits;
        logic long_reply;
    } itb_cmd_t;

    typedef struct packed {
        logic data_o;
        logic data_oe;
        logic clk;
        logic sel;
    } itb_nvm_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_SETTLE, ST_ACK, ST_TX_PULSE, ST_TX_GAP, ST_RX_START, ST_RX_BIT,
        ST_NVM, ST_DONE
    } itb_state_t;
endpackage
`default_nettype wire

/* hdl/itb_carrier_div.sv */
// Carrier generator: 14-bit binary divider of the 4 MHz reference
// Assumes clk is an integer multiple of the 4 MHz reference
`default_nettype none
module itb_carrier_div #(
    parameter int HALF_CYC = itb_pkg::SYS_HALF_CYC,
    parameter int TAP_HALF = itb_pkg::CAR_HALF_TICKS
) (
    input wire logic clk,
    input wire logic rst,
    output logic carrier
);
    localparam int TAP = $clog2(TAP_HALF);
    // Prescaler is 8 bits wide and the tap must be a power of two inside the counter
    if (HALF_CYC < 1 || HALF_CYC > 256 || TAP_HALF < 1 || (1 << TAP) != TAP_HALF
        || TAP >= itb_pkg::DIV_BITS) begin : g_bad_div
        $error("itb_carrier_div: bad division");
    end
    logic [7:0] pre_ff;
    logic ref_ff;
    logic [itb_pkg::DIV_BITS-1:0] cnt_ff;
    wire pre_wrap = (pre_ff == 8'(HALF_CYC - 1));
    wire ref_rise = pre_wrap && !ref_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre_ff <= 8'h00;
            ref_ff <= 1'b0;
            cnt_ff <= '0;
            carrier <= 1'b0;
        end else begin
            pre_ff <= pre_wrap ? 8'h00 : pre_ff + 8'h01;
            if (pre_wrap) ref_ff <= !ref_ff;
            if (ref_rise) cnt_ff <= cnt_ff + 1'b1;
            carrier <= cnt_ff[TAP];
        end
    end
endmodule
`default_nettype wire

/* hdl/itb_base_link.sv */
// Base station link engine: carrier, keyed commands, ack calibration, reply capture
// Assumes a host sequencer drives commands; return line arrives asynchronously
// Behaviour
// - Carrier comes from 14-bit division of 4 MHz to 125 kHz.
// - Field is keyed on and off by carrier_key_out only.
// - All link timing is whole multiples of base_time_element; the settle wait here is a fixed SETTLE_CYC count instead.
// - Commands go out as 5-bit opcodes, least significant bit first.
// - Extra command data follows the opcode where needed.
// - Learn request starts learning; learn state output shows progress.
// - Ignition scan request starts polling for a transponder.
// - Field active indicator is high while the field is on.
// - Authentic token pulse output pulses when a transponder is accepted.
// - Learned records live in an external serial memory with three lines.
// - Reply data is decoded from rising-edge intervals on the synchronised demodulated return line.
// - Command starts with 2 TE pulse; ones 6 TE, zeros 4 TE.
// - Wait 30 ms, calibrate 2 TE between acks, need three pairs.
// - Reply interval under 2 TE is zero; collect 18 or 34, drop preamble.
`default_nettype none
module itb_base_link #(
    parameter int SETTLE_CYC = itb_pkg::SETTLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic learn_request_in,
    input wire logic ignition_scan_request,
    input wire logic demod_return_in,
    input wire logic cmd_valid,
    input wire itb_pkg::itb_cmd_t cmd,
    input wire logic accept_token,
    input wire logic nvm_req,
    input wire logic [15:0] nvm_word,
    input wire logic nvm_data_io_in,
    output logic carrier_out,
    output logic carrier_key_out,
    output logic field_active_out,
    output logic authentic_token_out,
    output logic drive_enable_out,
    output logic [1:0] learn_state_out,
    output logic present_ff,
    output logic cmd_ready_ff,
    output logic rx_valid_ff,
    output logic [31:0] rx_data_ff,
    output logic nvm_data_io_out,
    output logic nvm_data_io_oe,
    output logic nvm_serial_clock,
    output logic nvm_select
);
    if (SETTLE_CYC < 1 || SETTLE_CYC >= 2 ** (itb_pkg::TE_W + 3)) begin : g_bad_settle
        $error("itb_base_link: settle count out of range");
    end
    localparam int TW = itb_pkg::TE_W;
    itb_pkg::itb_state_t st_ff;
    logic car_w;
    logic [2:0] ret_sync_ff;
    logic [TW+2:0] tmr_ff;
    logic [TW-1:0] te_ff;
    logic [1:0] pairs_ff;
    logic [5:0] bit_ff;
    logic [36:0] txsh_ff;
    logic [5:0] txlen_ff;
    logic [5:0] rxlen_ff;
    logic [31:0] rxsh_ff;
    logic [4:0] nvcnt_ff;
    logic [15:0] nvsh_ff;
    logic scan_ff, learn_ff, nvd_meta_ff, nvd_ff;
    logic [1:0] req_sync_ff;

    itb_carrier_div u_div (
        .clk(clk),
        .rst(rst),
        .carrier(car_w)
    );

    // Return line and pin requests pass two flops first
    wire ret_rise = ret_sync_ff[1] && !ret_sync_ff[2];
    wire scan_req = req_sync_ff[0];
    wire learn_req = req_sync_ff[1];
    wire [TW+2:0] te1 = {3'h0, te_ff};
    wire [TW+2:0] cmd_pulse = (TW+3)'(itb_pkg::CMD_START_TE) * te1;
    wire [TW+2:0] one_gap = (TW+3)'(itb_pkg::CMD_ONE_TE) * te1 - cmd_pulse;
    wire [TW+2:0] zero_gap = (TW+3)'(itb_pkg::CMD_ZERO_TE) * te1 - cmd_pulse;
    wire [TW+2:0] two_te = (TW+3)'(2) * te1;
    wire rx_bit = (tmr_ff >= two_te);
    wire tx_last = (bit_ff == txlen_ff);
    // Timer value at an edge is one short of the cycles elapsed
    wire [TW+2:0] tmr_inc = tmr_ff + (TW+3)'(1);
    wire field_on = (st_ff != itb_pkg::ST_IDLE) && (st_ff != itb_pkg::ST_NVM)
                    && (st_ff != itb_pkg::ST_DONE);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ret_sync_ff <= 3'h0;
            req_sync_ff <= 2'h0;
            scan_ff <= 1'b0;
            learn_ff <= 1'b0;
            nvd_meta_ff <= 1'b0;
            nvd_ff <= 1'b0;
        end else begin
            ret_sync_ff <= {ret_sync_ff[1:0], demod_return_in};
            scan_ff <= ignition_scan_request;
            learn_ff <= learn_request_in;
            req_sync_ff <= {learn_ff, scan_ff};
            nvd_meta_ff <= nvm_data_io_in;
            nvd_ff <= nvd_meta_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= itb_pkg::ST_IDLE;
            tmr_ff <= '0;
            te_ff <= itb_pkg::TE_RESET;
            pairs_ff <= 2'h0;
            bit_ff <= 6'h00;
            txsh_ff <= '0;
            txlen_ff <= 6'h00;
            rxlen_ff <= 6'h00;
            rxsh_ff <= 32'h00000000;
            nvcnt_ff <= 5'h00;
            nvsh_ff <= 16'h0000;
            carrier_key_out <= 1'b0;
            field_active_out <= 1'b0;
            present_ff <= 1'b0;
            cmd_ready_ff <= 1'b0;
            rx_valid_ff <= 1'b0;
            rx_data_ff <= 32'h00000000;
            learn_state_out <= itb_pkg::LEARN_IDLE;
            authentic_token_out <= 1'b0;
            drive_enable_out <= 1'b0;
            carrier_out <= 1'b0;
            nvm_data_io_out <= 1'b0;
            nvm_data_io_oe <= 1'b0;
            nvm_serial_clock <= 1'b0;
            nvm_select <= 1'b0;
        end else begin
            tmr_ff <= tmr_ff + 1'b1;
            rx_valid_ff <= 1'b0;
            authentic_token_out <= accept_token && present_ff;
            drive_enable_out <= accept_token ? 1'b1 : (drive_enable_out && scan_req);
            carrier_out <= car_w && carrier_key_out;
            field_active_out <= field_on;
            if (learn_req && learn_state_out == itb_pkg::LEARN_IDLE) begin
                learn_state_out <= itb_pkg::LEARN_BUSY;
            end else if (learn_state_out == itb_pkg::LEARN_BUSY && accept_token) begin
                learn_state_out <= itb_pkg::LEARN_DONE;
            end else if (!learn_req && learn_state_out == itb_pkg::LEARN_DONE) begin
                learn_state_out <= itb_pkg::LEARN_IDLE;
            end
            case (st_ff)
                itb_pkg::ST_IDLE: begin
                    carrier_key_out <= 1'b0;
                    present_ff <= 1'b0;
                    cmd_ready_ff <= 1'b0;
                    if (nvm_req) begin
                        st_ff <= itb_pkg::ST_NVM;
                        nvsh_ff <= nvm_word;
                        nvcnt_ff <= 5'h00;
                        nvm_select <= 1'b1;
                        nvm_data_io_oe <= 1'b1;
                    end else if (scan_req || learn_req) begin
                        st_ff <= itb_pkg::ST_SETTLE;
                        carrier_key_out <= 1'b1;
                        tmr_ff <= '0;
                    end
                end
                itb_pkg::ST_SETTLE: begin
                    if (tmr_ff >= (TW+3)'(SETTLE_CYC)) begin
                        st_ff <= itb_pkg::ST_ACK;
                        pairs_ff <= 2'h0;
                        bit_ff <= 6'h00;
                    end
                end
                itb_pkg::ST_ACK: begin
                    if (!(scan_req || learn_req)) st_ff <= itb_pkg::ST_IDLE;
                    else if (ret_rise) begin
                        tmr_ff <= '0;
                        if (bit_ff != 6'h00) begin
                            te_ff <= tmr_inc[TW:1];
                            pairs_ff <= pairs_ff + 2'h1;
                            if (pairs_ff == 2'(itb_pkg::ACK_PAIRS - 1)) begin
                                present_ff <= 1'b1;
                                cmd_ready_ff <= 1'b1;
                            end
                        end
                        bit_ff <= 6'h01;
                    end
                    if (cmd_ready_ff && cmd_valid) begin
                        cmd_ready_ff <= 1'b0;
                        txsh_ff <= {cmd.data, cmd.opcode};
                        txlen_ff <= 6'(itb_pkg::OPCODE_BITS) + cmd.data_bits;
                        rxlen_ff <= cmd.long_reply ? 6'(itb_pkg::RX_LONG_BITS)
                                                   : 6'(itb_pkg::RX_SHORT_BITS);
                        bit_ff <= 6'h00;
                        tmr_ff <= '0;
                        carrier_key_out <= 1'b0;
                        st_ff <= itb_pkg::ST_TX_PULSE;
                    end
                end
                itb_pkg::ST_TX_PULSE: begin
                    if (tmr_ff >= cmd_pulse) begin
                        carrier_key_out <= 1'b1;
                        tmr_ff <= '0;
                        st_ff <= tx_last ? itb_pkg::ST_RX_START : itb_pkg::ST_TX_GAP;
                    end
                end
                itb_pkg::ST_TX_GAP: begin
                    if (tmr_ff >= (txsh_ff[0] ? one_gap : zero_gap)) begin
                        txsh_ff <= txsh_ff >> 1;
                        bit_ff <= bit_ff + 6'h01;
                        carrier_key_out <= 1'b0;
                        tmr_ff <= '0;
                        st_ff <= itb_pkg::ST_TX_PULSE;
                    end
                end
                itb_pkg::ST_RX_START: begin
                    bit_ff <= 6'h00;
                    if (ret_rise) begin
                        tmr_ff <= '0;
                        st_ff <= itb_pkg::ST_RX_BIT;
                    end
                end
                itb_pkg::ST_RX_BIT: begin
                    if (ret_rise) begin
                        tmr_ff <= '0;
                        bit_ff <= bit_ff + 6'h01;
                        if (bit_ff >= 6'(itb_pkg::PREAMBLE_BITS)) begin
                            rxsh_ff <= {rx_bit, rxsh_ff[31:1]};
                        end
                        if (bit_ff + 6'h01 == rxlen_ff) begin
                            rx_valid_ff <= 1'b1;
                            rx_data_ff <= {rx_bit, rxsh_ff[31:1]};
                            cmd_ready_ff <= 1'b1;
                            bit_ff <= 6'h00;
                            st_ff <= itb_pkg::ST_ACK;
                        end
                    end
                end
                itb_pkg::ST_NVM: begin
                    nvm_serial_clock <= !nvm_serial_clock;
                    if (nvm_serial_clock) begin
                        nvsh_ff <= {nvsh_ff[14:0], nvd_ff};
                        nvcnt_ff <= nvcnt_ff + 5'h01;
                        if (nvcnt_ff == 5'h0f) st_ff <= itb_pkg::ST_DONE;
                    end else begin
                        nvm_data_io_out <= nvsh_ff[15];
                    end
                end
                itb_pkg::ST_DONE: begin
                    nvm_select <= 1'b0;
                    nvm_data_io_oe <= 1'b0;
                    nvm_serial_clock <= 1'b0;
                    rx_data_ff <= {16'h0000, nvsh_ff};
                    rx_valid_ff <= 1'b1;
                    st_ff <= itb_pkg::ST_IDLE;
                end
                default: st_ff <= itb_pkg::ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* verif/itb_base_link_asserts.sv */
// Checker for the base link outputs
// Assumes a 20-cycle time element from the partner acks
`default_nettype none
module itb_base_link_chk #(
    parameter int SETTLE_CYC = 200
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic learn_request_in,
    input wire logic ignition_scan_request,
    input wire logic accept_token,
    input wire logic nvm_req,
    input wire logic carrier_out,
    input wire logic carrier_key_out,
    input wire logic field_active_out,
    input wire logic authentic_token_out,
    input wire logic drive_enable_out,
    input wire logic [1:0] learn_state_out,
    input wire logic present_ff,
    input wire logic cmd_ready_ff,
    input wire logic rx_valid_ff,
    input wire logic nvm_serial_clock,
    input wire logic nvm_select
);
    logic [7:0] req_ff;
    logic [31:0] on_ff;
    logic [15:0] low_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_ff <= 8'h00;
            on_ff <= 32'h0;
            low_ff <= 16'h0;
        end else begin
            req_ff <= {req_ff[6:0], ignition_scan_request | learn_request_in};
            on_ff <= carrier_key_out ? on_ff + 32'h1 : 32'h0;
            low_ff <= carrier_key_out ? 16'h0 : low_ff + 16'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_key_needs_req: assert property ($rose(carrier_key_out) && !present_ff |-> |req_ff)
        else $error("key rose unrequested");
    a_field_follows: assert property ($rose(carrier_key_out) && !present_ff |=> field_active_out)
        else $error("field flag late");
    a_carrier_gated: assert property (!carrier_key_out && !$past(carrier_key_out) |-> !carrier_out)
        else $error("carrier while keyed off");
    a_field_idle: assert property (!carrier_key_out && !$past(carrier_key_out) && !present_ff
        |-> !field_active_out)
        else $error("field flag while idle");
    a_settle_wait: assert property ($rose(present_ff) |-> on_ff >= SETTLE_CYC)
        else $error("present too early");
    a_low_two_te: assert property ($rose(carrier_key_out) && present_ff |-> low_ff inside {[38:42]})
        else $error("key low pulse length");
    a_cmd_refused: assert property (cmd_ready_ff |-> present_ff)
        else $error("ready without present");
    a_token_cause: assert property (authentic_token_out |-> $past(accept_token) && $past(present_ff))
        else $error("token without accept");
    a_token_answer: assert property (accept_token && present_ff |=> authentic_token_out)
        else $error("token missing");
    a_drive_cause: assert property ($rose(drive_enable_out) |-> $past(accept_token))
        else $error("drive enable uncaused");
    a_rx_pulse: assert property (rx_valid_ff |=> !rx_valid_ff)
        else $error("rx valid too long");
    a_nvm_start: assert property (nvm_req && !field_active_out && !present_ff |=> nvm_select)
        else $error("nvm select late");
    a_nvm_clk_sel: assert property (nvm_serial_clock |-> nvm_select)
        else $error("nvm clock unselected");
    a_learn_busy: assert property ($rose(learn_request_in) && learn_state_out == itb_pkg::LEARN_IDLE
        |-> ##[2:6] learn_state_out == itb_pkg::LEARN_BUSY)
        else $error("learn not busy");
endmodule
bind itb_base_link itb_base_link_chk #(.SETTLE_CYC(SETTLE_CYC)) u_chk (
    .clk(clk), .rst(rst), .learn_request_in(learn_request_in),
    .ignition_scan_request(ignition_scan_request), .accept_token(accept_token),
    .nvm_req(nvm_req), .carrier_out(carrier_out), .carrier_key_out(carrier_key_out),
    .field_active_out(field_active_out), .authentic_token_out(authentic_token_out),
    .drive_enable_out(drive_enable_out), .learn_state_out(learn_state_out),
    .present_ff(present_ff), .cmd_ready_ff(cmd_ready_ff), .rx_valid_ff(rx_valid_ff),
    .nvm_serial_clock(nvm_serial_clock), .nvm_select(nvm_select));
`default_nettype wire

/* verif/itb_xpdr_model.sv */
// Behavioural transponder on the far side of the field
// Assumes the bench gives the command bit count
`default_nettype none
module itb_xpdr_model #(
    parameter int TE = 20,
    parameter int RT = 15
) (
    input wire logic clk,
    input wire logic field,
    input wire logic [5:0] cmd_bits,
    input wire logic [31:0] reply_word,
    output logic demod,
    output logic [31:0] got_cmd
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;
    int i;
    int g;
    logic b;
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wait_rise(output int gap);
        logic p;
        gap = 0;
        do begin
            p = field;
            step(1);
            gap++;
        end while (!(field && !p) && gap < 8 * TE);
    endtask
    initial begin
        demod = 1'b0;
        got_cmd = 32'h0;
        forever begin
            @(posedge clk iff field);
            step(50);
            n = 0;
            while (field) begin
                demod = (n % (2 * TE)) < 4;
                n++;
                step(1);
            end
            demod = 1'b0;
            if (cmd_bits != 6'h00) begin
                wait_rise(g);
                for (i = 0; i < cmd_bits && g < 8 * TE; i++) begin
                    wait_rise(g);
                    got_cmd[i] = g > 5 * TE;
                end
                step(2 * TE);
                for (i = 0; i <= 34; i++) begin
                    b = (i < 2) ? (i == 0) : reply_word[i - 2];
                    demod = 1'b1;
                    step(5);
                    demod = 1'b0;
                    if (i < 34) step(RT * (b ? 3 : 2) - 5);
                end
            end
        end
    end
endmodule
`default_nettype wire

/* verif/tb_itb_base_link.sv */
// Self-checking bench for the transponder base link
// Assumes the partner model and the bound checker
`default_nettype none
module tb_itb_base_link;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic learn_request_in = 1'b0;
    logic ignition_scan_request = 1'b0;
    logic cmd_valid = 1'b0;
    logic accept_token = 1'b0;
    logic nvm_req = 1'b0;
    logic [15:0] nvm_word = 16'hb4c1;
    itb_pkg::itb_cmd_t cmd = '0;
    logic [5:0] cmd_bits = 6'h00;
    logic [31:0] reply_word = 32'hc3a5_0f96;
    logic demod, nvm_di, car, key, fld, tok, drv, pres, rdy, rxv, dout, doe, nclk, nsel;
    logic [1:0] lrn;
    logic [31:0] rxd, got_cmd;
    int bad_count = 0;
    int checks = 0;
    int t;
    int k;
    assign nvm_di = ~dout;
    always #2.5 clk = ~clk;
    itb_base_link #(.SETTLE_CYC(200)) u_dut (
        .clk(clk), .rst(rst), .learn_request_in(learn_request_in),
        .ignition_scan_request(ignition_scan_request), .demod_return_in(demod),
        .cmd_valid(cmd_valid), .cmd(cmd), .accept_token(accept_token), .nvm_req(nvm_req),
        .nvm_word(nvm_word), .nvm_data_io_in(nvm_di), .carrier_out(car),
        .carrier_key_out(key), .field_active_out(fld), .authentic_token_out(tok),
        .drive_enable_out(drv), .learn_state_out(lrn), .present_ff(pres),
        .cmd_ready_ff(rdy), .rx_valid_ff(rxv), .rx_data_ff(rxd), .nvm_data_io_out(dout),
        .nvm_data_io_oe(doe), .nvm_serial_clock(nclk), .nvm_select(nsel));
    itb_xpdr_model u_xpdr (.clk(clk), .field(key), .cmd_bits(cmd_bits),
        .reply_word(reply_word), .demod(demod), .got_cmd(got_cmd));
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic do_reset();
        rst = 1'b1;
        ignition_scan_request = 1'b0;
        learn_request_in = 1'b0;
        step(5);
        rst = 1'b0;
        step(1);
    endtask
    task automatic final_report();
        $display("checks %0d bad %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_car(input logic v, output int n);
        n = 0;
        while (car !== v && n < 5000) begin
            step(1);
            n++;
        end
    endtask
    task automatic t_poll();
        chk("key_idle", {fld, key, tok, drv, lrn}, 0);
        ignition_scan_request = 1'b1;
        for (t = 0; key !== 1'b1 && t < 20; t++) step(1);
        chk("key_on", key, 1);
        step(1);
        chk("field_on", fld, 1);
        for (t = 0; pres !== 1'b1 && t < 3000; t++) step(1);
        chk("present", pres, 1);
        chk("settle", t >= 200, 1);
        wait_car(0, t);
        wait_car(1, t);
        wait_car(0, t);
        wait_car(1, k);
        chk("carrier_period", t + k, 1600);
        $display("poll test done");
    endtask
    task automatic t_command();
        cmd_bits = 6'd13;
        cmd = '{opcode: 5'h16, data: 32'h0000_00a5, data_bits: 6'd8, long_reply: 1'b1};
        cmd_valid = 1'b1;
        for (t = 0; rdy !== 1'b1 && t < 100; t++) step(1);
        step(1);
        cmd_valid = 1'b0;
        for (t = 0; rxv !== 1'b1 && t < 10000; t++) step(1);
        chk("rx_valid", rxv, 1);
        chk("rx_data", rxd, reply_word);
        chk("cmd_seen", got_cmd & 32'h1fff, {19'h0, 8'ha5, 5'h16});
        cmd_bits = 6'h00;
        $display("command test done");
    endtask
    task automatic t_token();
        accept_token = 1'b1;
        step(1);
        accept_token = 1'b0;
        chk("token_on", tok, 1);
        step(1);
        chk("token_off", tok, 0);
        chk("drive_on", drv, 1);
        ignition_scan_request = 1'b0;
        step(8);
        chk("drive_off", drv, 0);
        $display("token test done");
    endtask
    task automatic t_learn();
        do_reset();
        learn_request_in = 1'b1;
        step(6);
        chk("learn_busy", lrn, itb_pkg::LEARN_BUSY);
        chk("learn_key", key, 1);
        accept_token = 1'b1;
        step(1);
        accept_token = 1'b0;
        chk("learn_done", lrn, itb_pkg::LEARN_DONE);
        chk("token_gated", tok, 0);
        do_reset();
        $display("learn test done");
    endtask
    task automatic t_nvm();
        nvm_req = 1'b1;
        step(1);
        nvm_req = 1'b0;
        step(1);
        chk("nvm_sel", {nsel, doe}, 2'h3);
        k = (nclk === 1'b1) ? 1 : 0;
        for (t = 0; rxv !== 1'b1 && t < 200; t++) begin
            step(1);
            if (nclk === 1'b1) k++;
        end
        chk("nvm_clocks", k, 16);
        // Inverting loopback: each bit returns one clock pair late
        chk("nvm_data", rxd, 32'h0000_a59f);
        chk("nvm_field", fld, 0);
        $display("nvm test done");
    endtask
    initial begin
        step(60000);
        bad_count++;
        $display("watchdog expired");
        final_report();
    end
    initial begin
        do_reset();
        t_poll();
        t_command();
        t_token();
        t_learn();
        t_nvm();
        final_report();
    end
endmodule
`default_nettype wire
